// ---- logic/fepc_sequencer.v ----
// Erase and program command decoder and self-timed sequencer of a serial NOR flash.
`timescale 1ns/1ps
`include "fepc_defs.vh"

// Function
// - Command FFH in four-line mode returns the device to single-line command mode.
// - Leaving four-line mode keeps write latch, suspend status and wrap length.
// - Command 20H wipes the sector chosen by address bits A12 and up.
// - Erases execute only if chip select rises exactly on a byte boundary.
// - Valid sector wipe starts timed cycle, busy high, then busy and latch cleared.
// - A sector covered by block protect bits is never wiped.
// - Command 52H wipes the 32K block holding the given address.
// - Half-block wipe is timed; protected block unchanged but latch still cleared.
// - Command D8H wipes 64K block, timed, clears latch, skipped if protected.
// - Commands 60H and C7H wipe whole array only when nothing is protected.
// - Array wipe starts at chip select high, busy throughout, latch cleared after.
// - Page write address wraps inside the current page.
// - More than 256 data bytes keeps only the final 256.
// - Fewer than 256 bytes programs just those at their addresses.
// - Page write executes only if chip select rises after a whole data byte.
// - Page write is timed with busy high, clears latch, skipped if protected.
// - Single-line erase and program ignore the upper three shared lines.
// - Quad-allowed bit is status bit nine and gates four-line commands.
// - Command 38H enters four-line mode only while quad-allowed bit is one.
module fepc_sequencer #(
    parameter SMALL_WIPE_CYC = `FEPC_SMALL_WIPE_TIME_US * `FEPC_CLK_MHZ,
    parameter HALF_WIPE_CYC = `FEPC_HALF_WIPE_TIME_US * `FEPC_CLK_MHZ,
    parameter BLOCK_WIPE_CYC = `FEPC_BLOCK_WIPE_TIME_US * `FEPC_CLK_MHZ,
    parameter ARRAY_WIPE_CYC = `FEPC_ARRAY_WIPE_TIME_US * `FEPC_CLK_MHZ,
    parameter PAGE_WRITE_CYC = `FEPC_PAGE_WRITE_TIME_US * `FEPC_CLK_MHZ
)(
    // Clock, reset and enable.
    input wire core_clk,
    input wire nrst,
    input wire clk_en,
    // Serial link pins.
    input wire link_sck,
    input wire link_cs_n,
    input wire [3:0] shared_io_lines,
    // Configuration and status.
    input wire [15:0] status_word,
    input wire [2:0] block_protect_bits,
    input wire [21:0] wrap_and_suspend_in,
    output reg write_latch_flag,
    output reg busy_flag,
    output reg four_line_cmd_mode,
    output reg status_poll,
    // Array operation strobes.
    output reg wipe_go,
    output reg [2:0] wipe_kind,
    output reg [23:0] wipe_addr,
    output reg page_we,
    output reg [7:0] page_wr_col,
    output reg [7:0] page_wr_data,
    output reg page_commit,
    output reg [23:0] page_base
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------

    // Two stages on every pin; only the second stage is read by logic.
    reg [5:0] sync1_r;
    reg [5:0] sync2_r;
    reg sck_d_r;
    wire sck_s = sync2_r[0];
    wire cs_s = sync2_r[1];
    wire [3:0] io_s = sync2_r[5:2];
    wire sck_rise = sck_s & ~sck_d_r & ~cs_s;

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sync1_r <= 6'h02;
            sync2_r <= 6'h02;
            sck_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1_r <= {shared_io_lines, link_cs_n, link_sck};
            sync2_r <= sync1_r;
            sck_d_r <= sck_s;
        end
    end

    // ----------------------------------------------------------------
    // Shift and decode
    // ----------------------------------------------------------------

    reg [1:0] phase_r;          // 0 command, 1 address, 2 data, 3 ignore.
    reg [7:0] cmd_r;
    reg [7:0] shift_r;
    reg [3:0] bitcnt_r;
    reg [1:0] addr_bytes_r;
    reg [23:0] addr_r;
    reg [7:0] col_r;
    reg data_seen_r;
    reg quad_data_r;
    reg cs_d_r;
    reg [2:0] op_r;
    reg [22:0] timer_r;

    wire qe_on = status_word[`FEPC_QE_BIT];
    wire wide = four_line_cmd_mode | (phase_r == 2'h2 & quad_data_r);
    // Single-line framing looks only at line zero; upper lines are ignored.
    wire [7:0] shift_nxt = wide ? {shift_r[3:0], io_s} : {shift_r[6:0], io_s[0]};
    wire [3:0] bit_step = wide ? 4'h4 : 4'h1;
    wire [3:0] bitcnt_nxt = bitcnt_r + bit_step;
    wire byte_done = sck_rise & (bitcnt_nxt == 4'h8);
    wire cs_rise = cs_s & ~cs_d_r;
    wire on_boundary = (bitcnt_r == 4'h0);
    wire nothing_protected = (block_protect_bits == 3'h0);
    // Simple protection: any nonzero protect code covers the top region selected by it.
    wire [2:0] region = addr_r[23:21];
    wire covered = ~nothing_protected & (region >= (3'h7 - block_protect_bits + 3'h1));
    wire is_wipe = (cmd_r == `FEPC_CMD_SMALL_WIPE) | (cmd_r == `FEPC_CMD_HALF_WIPE) |
                   (cmd_r == `FEPC_CMD_BLOCK_WIPE);
    wire is_array = (cmd_r == `FEPC_CMD_ARRAY_WIPE_A) | (cmd_r == `FEPC_CMD_ARRAY_WIPE_B);
    wire is_page = (cmd_r == `FEPC_CMD_PAGE_WRITE) | (cmd_r == `FEPC_CMD_QUAD_PAGE_WRITE);

    // The suspend and wrap inputs are owned outside; mode changes never touch them.
    wire unused_keep = |wrap_and_suspend_in;

    // Frame decoder: takes command byte, address bytes and page data.
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            phase_r <= 2'h0;
            cmd_r <= 8'h00;
            shift_r <= 8'h00;
            bitcnt_r <= 4'h0;
            addr_bytes_r <= 2'h0;
            addr_r <= 24'h000000;
            col_r <= 8'h00;
            data_seen_r <= 1'b0;
            quad_data_r <= 1'b0;
            cs_d_r <= 1'b1;
            four_line_cmd_mode <= 1'b0;
            status_poll <= 1'b0;
            page_we <= 1'b0;
            page_wr_col <= 8'h00;
            page_wr_data <= 8'h00;
        end
        else if (clk_en)
        begin
            cs_d_r <= cs_s;
            page_we <= 1'b0;
            if (cs_s)
            begin
                phase_r <= 2'h0;
                bitcnt_r <= 4'h0;
                addr_bytes_r <= 2'h0;
                status_poll <= 1'b0;
                if (!cs_d_r)
                    data_seen_r <= data_seen_r;
                else
                    data_seen_r <= 1'b0;
            end
            else if (sck_rise)
            begin
                shift_r <= shift_nxt;
                bitcnt_r <= byte_done ? 4'h0 : bitcnt_nxt;
                if (byte_done)
                begin
                    case (phase_r)
                        2'h0:
                        begin
                            cmd_r <= shift_nxt;
                            data_seen_r <= 1'b0;
                            // Quad data only with the quad-allowed bit; else single-line.
                            quad_data_r <= (shift_nxt == `FEPC_CMD_QUAD_PAGE_WRITE) & qe_on;
                            // Status read stays decodable while a timed cycle runs.
                            status_poll <= (shift_nxt == `FEPC_CMD_READ_STATUS);
                            if (shift_nxt == `FEPC_CMD_QUAD_ENTER & qe_on & ~four_line_cmd_mode)
                                four_line_cmd_mode <= 1'b1;
                            if (shift_nxt == `FEPC_CMD_QUAD_EXIT & four_line_cmd_mode)
                                four_line_cmd_mode <= 1'b0;
                            if (shift_nxt == `FEPC_CMD_SMALL_WIPE | shift_nxt == `FEPC_CMD_HALF_WIPE |
                                shift_nxt == `FEPC_CMD_BLOCK_WIPE | shift_nxt == `FEPC_CMD_PAGE_WRITE |
                                shift_nxt == `FEPC_CMD_QUAD_PAGE_WRITE)
                                phase_r <= 2'h1;
                            else
                                phase_r <= 2'h3;
                        end
                        2'h1:
                        begin
                            addr_r <= {addr_r[15:0], shift_nxt};
                            addr_bytes_r <= addr_bytes_r + 2'h1;
                            if (addr_bytes_r == 2'h2)
                            begin
                                phase_r <= is_page ? 2'h2 : 2'h3;
                                col_r <= shift_nxt;
                            end
                        end
                        2'h2:
                        begin
                            // Column wraps in the page; later bytes overwrite earlier ones.
                            page_we <= ~busy_flag & write_latch_flag;
                            page_wr_col <= col_r;
                            page_wr_data <= shift_nxt;
                            col_r <= col_r + 8'h01;
                            data_seen_r <= 1'b1;
                        end
                        default:
                        begin
                            // A whole byte past the last address byte is an overrun that erases refuse.
                            phase_r <= 2'h3;
                            data_seen_r <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Self-timed cycle
    // ----------------------------------------------------------------

    // Start check at chip select rise, then count down the cycle.
    reg accept;
    reg [2:0] kind;
    reg [22:0] load;
    always @*
    begin
        accept = 1'b0;
        kind = `FEPC_OP_NONE;
        load = 23'h000000;
        if (is_wipe & phase_r == 2'h3 & addr_bytes_r == 2'h3 & on_boundary & ~data_seen_r)
        begin
            accept = 1'b1;
            if (cmd_r == `FEPC_CMD_SMALL_WIPE)
            begin
                kind = `FEPC_OP_SMALL;
                load = SMALL_WIPE_CYC[22:0];
            end
            else if (cmd_r == `FEPC_CMD_HALF_WIPE)
            begin
                kind = `FEPC_OP_HALF;
                load = HALF_WIPE_CYC[22:0];
            end
            else
            begin
                kind = `FEPC_OP_BLOCK;
                load = BLOCK_WIPE_CYC[22:0];
            end
        end
        else if (is_array & phase_r == 2'h3 & addr_bytes_r == 2'h0 & on_boundary & ~data_seen_r)
        begin
            accept = 1'b1;
            kind = `FEPC_OP_ARRAY;
            load = ARRAY_WIPE_CYC[22:0];
        end
        else if (is_page & phase_r == 2'h2 & data_seen_r & on_boundary)
        begin
            accept = 1'b1;
            kind = `FEPC_OP_PAGE;
            load = PAGE_WRITE_CYC[22:0];
        end
    end

    // The write latch is armed by write-arm; every accepted timed cycle clears it at the end.
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            write_latch_flag <= 1'b0;
            busy_flag <= 1'b0;
            op_r <= `FEPC_OP_NONE;
            timer_r <= 23'h000000;
            wipe_go <= 1'b0;
            wipe_kind <= `FEPC_OP_NONE;
            wipe_addr <= 24'h000000;
            page_commit <= 1'b0;
            page_base <= 24'h000000;
        end
        else if (clk_en)
        begin
            wipe_go <= 1'b0;
            page_commit <= 1'b0;
            if (byte_done & phase_r == 2'h0 & shift_nxt == `FEPC_CMD_WRITE_ARM & ~busy_flag)
                write_latch_flag <= 1'b1;
            if (busy_flag)
            begin
                if (timer_r <= 23'h000001)
                begin
                    busy_flag <= 1'b0;
                    write_latch_flag <= 1'b0;
                    op_r <= `FEPC_OP_NONE;
                end
                else
                    timer_r <= timer_r - 23'h000001;
            end
            else if (cs_rise & accept & write_latch_flag)
            begin
                busy_flag <= 1'b1;
                op_r <= kind;
                timer_r <= load;
                wipe_kind <= kind;
                wipe_addr <= addr_r;
                page_base <= {addr_r[23:8], 8'h00};
                // Protected targets keep their data; the cycle still runs and clears the latch.
                if (kind == `FEPC_OP_PAGE)
                    page_commit <= ~covered;
                else if (kind == `FEPC_OP_ARRAY)
                    wipe_go <= nothing_protected;
                else
                    wipe_go <= ~covered;
            end
        end
    end

endmodule

// ---- logic/fepc_defs.vh ----
// Constants for the flash erase and program command sequencer.
`ifndef FEPC_DEFS_VH
`define FEPC_DEFS_VH
`define FEPC_CMD_WRITE_ARM 8'h06
`define FEPC_CMD_QUAD_ENTER 8'h38
`define FEPC_CMD_QUAD_EXIT 8'hFF
`define FEPC_CMD_SMALL_WIPE 8'h20
`define FEPC_CMD_HALF_WIPE 8'h52
`define FEPC_CMD_BLOCK_WIPE 8'hD8
`define FEPC_CMD_ARRAY_WIPE_A 8'h60
`define FEPC_CMD_ARRAY_WIPE_B 8'hC7
`define FEPC_CMD_PAGE_WRITE 8'h02
`define FEPC_CMD_QUAD_PAGE_WRITE 8'h32
`define FEPC_CMD_READ_STATUS 8'h05
`define FEPC_OP_NONE 3'h0
`define FEPC_OP_SMALL 3'h1
`define FEPC_OP_HALF 3'h2
`define FEPC_OP_BLOCK 3'h3
`define FEPC_OP_ARRAY 3'h4
`define FEPC_OP_PAGE 3'h5
`define FEPC_QE_BIT 9
`define FEPC_SMALL_WIPE_TIME_US 45
`define FEPC_HALF_WIPE_TIME_US 150
`define FEPC_BLOCK_WIPE_TIME_US 250
`define FEPC_ARRAY_WIPE_TIME_US 2000
`define FEPC_PAGE_WRITE_TIME_US 600
`define FEPC_CLK_MHZ 125
`endif

// ---- testbench/fepc_host_model.sv ----
// Host-side serial controller model that drives the flash link pins.
`timescale 1ns/1ps
module fepc_host_model (
    // Pacing clock.
    input wire core_clk,
    // Link pins.
    output reg link_sck,
    output reg link_cs_n,
    output reg [3:0] shared_io_lines
);
    // Link idles with clock low and select high.
    initial
    begin
        link_sck = 1'b0;
        link_cs_n = 1'b1;
        shared_io_lines = 4'hA;
    end
    // Half of a 64 ns link period.
    task half;
        repeat (4) @(posedge core_clk);
    endtask
    // One clock pulse; data settles a half period before the rise.
    task pulse(input [3:0] v);
        begin
            shared_io_lines <= v;
            half;
            link_sck <= 1'b1;
            half;
            link_sck <= 1'b0;
        end
    endtask
    // First n bits, MSB first on line zero; upper lines churn.
    task bitn(input [7:0] b, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
                pulse({~shared_io_lines[3:1], b[7 - i]});
        end
    endtask
    // A whole byte, on one line or as two nibbles.
    task byte_out(input [7:0] b, input q);
        begin
            if (q)
            begin
                pulse(b[7:4]);
                pulse(b[3:0]);
            end
            else
                bitn(b, 8);
        end
    endtask
    // Select framing around each command.
    task open;
        begin
            @(posedge core_clk);
            link_cs_n <= 1'b0;
            half;
        end
    endtask
    task close;
        begin
            half;
            link_cs_n <= 1'b1;
            shared_io_lines <= ~shared_io_lines;
            repeat (8) @(posedge core_clk);
        end
    endtask
endmodule

// ---- testbench/fepc_monitor.sv ----
// Checker of the sequencer's port behaviour.
`timescale 1ns/1ps
`include "fepc_defs.vh"
module fepc_monitor (
    // Clock and reset.
    input wire core_clk,
    input wire nrst,
    input wire clk_en,
    // Link pins.
    input wire link_sck,
    input wire link_cs_n,
    input wire [3:0] shared_io_lines,
    // Configuration and status.
    input wire [15:0] status_word,
    input wire [2:0] block_protect_bits,
    input wire [21:0] wrap_and_suspend_in,
    input wire write_latch_flag,
    input wire busy_flag,
    input wire four_line_cmd_mode,
    input wire status_poll,
    // Array strobes.
    input wire wipe_go,
    input wire [2:0] wipe_kind,
    input wire [23:0] wipe_addr,
    input wire page_we,
    input wire [7:0] page_wr_col,
    input wire [7:0] page_wr_data,
    input wire page_commit,
    input wire [23:0] page_base
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // A start strobe is never seen without the cycle running.
    sequence busy_soon;
        ##[0:1] busy_flag;
    endsequence
    go_busy_a: assert property (wipe_go |-> busy_soon) else $error("wipe start without busy");
    commit_busy_a: assert property (page_commit |-> busy_soon) else $error("commit without busy");
    latch_clear_a: assert property ($fell(busy_flag) |-> !write_latch_flag) else $error("latch kept");
    armed_start_a: assert property ($rose(busy_flag) |-> $past(write_latch_flag)) else $error("unarmed");
    cs_start_a: assert property ($rose(busy_flag) |-> link_cs_n) else $error("cycle inside frame");
    array_prot_a: assert property (wipe_go && wipe_kind == `FEPC_OP_ARRAY |-> block_protect_bits == 3'h0)
        else $error("protected array wiped");
    write_gate_a: assert property (page_we |-> write_latch_flag && !busy_flag) else $error("bad write");
    quad_enter_a: assert property ($rose(four_line_cmd_mode) |-> status_word[`FEPC_QE_BIT])
        else $error("quad mode without permit");
    mode_keep_a: assert property ($changed(four_line_cmd_mode) |-> $stable(write_latch_flag))
        else $error("latch moved on mode change");
endmodule
bind fepc_sequencer fepc_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .link_sck(link_sck),
    .link_cs_n(link_cs_n), .shared_io_lines(shared_io_lines), .status_word(status_word),
    .block_protect_bits(block_protect_bits), .wrap_and_suspend_in(wrap_and_suspend_in),
    .write_latch_flag(write_latch_flag), .busy_flag(busy_flag), .four_line_cmd_mode(four_line_cmd_mode),
    .status_poll(status_poll), .wipe_go(wipe_go), .wipe_kind(wipe_kind), .wipe_addr(wipe_addr),
    .page_we(page_we), .page_wr_col(page_wr_col), .page_wr_data(page_wr_data), .page_commit(page_commit),
    .page_base(page_base));

// ---- testbench/testbench.sv ----
// Self-checking testbench of the erase and program sequencer.
`timescale 1ns/1ps
`include "fepc_defs.vh"
module testbench;
    // Shortened cycle lengths keep the run brief.
    localparam C1 = 20, C2 = 24, C3 = 28, C4 = 32, C5 = 36;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [15:0] status_word = 16'h0000;
    reg [2:0] block_protect_bits = 3'h0;
    reg clk_en = 1'b1;
    wire status_poll;
    wire link_sck, link_cs_n, write_latch_flag, busy_flag, four_line_cmd_mode, wipe_go, page_we, page_commit;
    wire [3:0] shared_io_lines;
    wire [2:0] wipe_kind;
    wire [23:0] wipe_addr, page_base;
    wire [7:0] page_wr_col, page_wr_data;
    integer num_errors = 0, n_compared = 0, busy_n = 0, start_n = 0, we_n = 0;
    reg [2:0] kind_seen = 3'h0;
    reg [23:0] addr_seen = 24'h000000;
    reg [7:0] col_seen = 8'h00, dat_seen = 8'h00;
    always #4 core_clk = ~core_clk;
    fepc_host_model u_host (.core_clk(core_clk), .link_sck(link_sck), .link_cs_n(link_cs_n),
        .shared_io_lines(shared_io_lines));
    fepc_sequencer #(.SMALL_WIPE_CYC(C1), .HALF_WIPE_CYC(C2), .BLOCK_WIPE_CYC(C3), .ARRAY_WIPE_CYC(C4),
        .PAGE_WRITE_CYC(C5)) u_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .link_sck(link_sck),
        .link_cs_n(link_cs_n), .shared_io_lines(shared_io_lines), .status_word(status_word),
        .block_protect_bits(block_protect_bits), .wrap_and_suspend_in(22'h000000),
        .write_latch_flag(write_latch_flag), .busy_flag(busy_flag), .four_line_cmd_mode(four_line_cmd_mode),
        .status_poll(status_poll), .wipe_go(wipe_go), .wipe_kind(wipe_kind), .wipe_addr(wipe_addr),
        .page_we(page_we), .page_wr_col(page_wr_col), .page_wr_data(page_wr_data), .page_commit(page_commit),
        .page_base(page_base));
    // Tally busy cycles, starts and byte writes as they pass.
    always @(posedge core_clk)
    begin
        if (busy_flag === 1'b1) busy_n = busy_n + 1;
        if (wipe_go === 1'b1)
        begin
            start_n = start_n + 1;
            kind_seen = wipe_kind;
            addr_seen = wipe_addr;
        end
        if (page_commit === 1'b1)
        begin
            start_n = start_n + 1;
            kind_seen = `FEPC_OP_PAGE;
            addr_seen = page_base;
        end
        if (page_we === 1'b1)
        begin
            we_n = we_n + 1;
            col_seen = page_wr_col;
            dat_seen = page_wr_data;
        end
    end
    task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("BAD %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (num_errors == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task frame(input [7:0] b, input q);
        begin
            u_host.open;
            u_host.byte_out(b, q);
            u_host.close;
        end
    endtask
    // Arm writes first; every erase or program needs it.
    task arm;
        frame(`FEPC_CMD_WRITE_ARM, 1'b0);
    endtask
    // One erase or program frame, then judge the cycle it caused.
    task xfer(input [7:0] cmd, input [23:0] a, input integer nad, input integer nd, input q, input integer tail,
        input integer cyc, input integer go, input [2:0] kind, input [23:0] mask, input lat);
        integer i;
        begin
            busy_n = 0;
            start_n = 0;
            we_n = 0;
            u_host.open;
            u_host.byte_out(cmd, 1'b0);
            for (i = 2; i > 2 - nad; i = i - 1)
                u_host.byte_out(a[i * 8 +: 8], 1'b0);
            for (i = 0; i < nd; i = i + 1)
                u_host.byte_out(8'h3C + i[7:0], q);
            if (tail > 0) u_host.bitn(8'h96, tail);
            u_host.close;
            for (i = 0; i < 4000 && busy_flag !== 1'b0; i = i + 1) @(posedge core_clk);
            repeat (2) @(posedge core_clk);
            check("busy_cyc", busy_n, cyc);
            check("starts", start_n, go);
            if (go > 0) check("kind", kind_seen, kind);
            if (go > 0) check("addr", addr_seen & mask, a & mask);
            check("writes", we_n, nd);
            if (nd > 0) check("col", col_seen, (a[7:0] + nd - 1) & 32'hFF);
            if (nd > 0) check("data", dat_seen, (32'h3C + nd - 1) & 32'hFF);
            check("latch", write_latch_flag, lat);
        end
    endtask
    // Four-line mode needs the quad-allowed bit; leaving it keeps the latch.
    task mode_trip;
        begin
            frame(`FEPC_CMD_QUAD_ENTER, 1'b0);
            check("mode", four_line_cmd_mode, 0);
            @(posedge core_clk);
            status_word <= 16'h0200;
            arm;
            frame(`FEPC_CMD_QUAD_ENTER, 1'b0);
            check("mode", four_line_cmd_mode, 1);
            frame(`FEPC_CMD_QUAD_EXIT, 1'b1);
            check("mode", four_line_cmd_mode, 0);
            check("latch", write_latch_flag, 1);
        end
    endtask
    // A frozen core must miss a whole write-arm frame and resume without false edges.
    task freeze_arm;
        begin
            @(posedge core_clk);
            clk_en <= 1'b0;
            frame(`FEPC_CMD_WRITE_ARM, 1'b0);
            clk_en <= 1'b1;
            repeat (4) @(posedge core_clk);
            check("frozen", write_latch_flag, 0);
        end
    endtask
    // A status read raises the poll level only while its frame is open.
    task status_read;
        begin
            u_host.open;
            u_host.byte_out(`FEPC_CMD_READ_STATUS, 1'b0);
            repeat (4) @(posedge core_clk);
            check("poll_open", status_poll, 1);
            u_host.close;
            check("poll_shut", status_poll, 0);
        end
    endtask
    // Watchdog sized well above the expected run.
    initial
    begin
        repeat (90000) @(posedge core_clk);
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        arm;
        xfer(`FEPC_CMD_SMALL_WIPE, 24'h123456, 3, 0, 0, 0, C1, 1, `FEPC_OP_SMALL, 24'hFFF000, 0);
        arm;
        xfer(`FEPC_CMD_HALF_WIPE, 24'h13579B, 3, 0, 0, 0, C2, 1, `FEPC_OP_HALF, 24'hFF8000, 0);
        arm;
        xfer(`FEPC_CMD_BLOCK_WIPE, 24'h2468AC, 3, 0, 0, 0, C3, 1, `FEPC_OP_BLOCK, 24'hFF0000, 0);
        arm;
        xfer(`FEPC_CMD_ARRAY_WIPE_A, 24'h0, 0, 0, 0, 0, C4, 1, `FEPC_OP_ARRAY, 24'h0, 0);
        arm;
        xfer(`FEPC_CMD_ARRAY_WIPE_B, 24'h0, 0, 0, 0, 0, C4, 1, `FEPC_OP_ARRAY, 24'h0, 0);
        xfer(`FEPC_CMD_SMALL_WIPE, 24'h001000, 3, 0, 0, 0, 0, 0, 3'h0, 24'h0, 0);
        arm;
        xfer(`FEPC_CMD_SMALL_WIPE, 24'h001000, 3, 0, 0, 3, 0, 0, 3'h0, 24'h0, 1);
        xfer(`FEPC_CMD_SMALL_WIPE, 24'h001000, 3, 0, 0, 8, 0, 0, 3'h0, 24'h0, 1);
        @(posedge core_clk);
        block_protect_bits <= 3'h1;
        xfer(`FEPC_CMD_SMALL_WIPE, 24'hF00000, 3, 0, 0, 0, C1, 0, 3'h0, 24'h0, 0);
        arm;
        xfer(`FEPC_CMD_HALF_WIPE, 24'hE12345, 3, 0, 0, 0, C2, 0, 3'h0, 24'h0, 0);
        arm;
        xfer(`FEPC_CMD_ARRAY_WIPE_A, 24'h0, 0, 0, 0, 0, C4, 0, 3'h0, 24'h0, 0);
        @(posedge core_clk);
        block_protect_bits <= 3'h0;
        arm;
        xfer(`FEPC_CMD_PAGE_WRITE, 24'h0A0BFE, 3, 3, 0, 0, C5, 1, `FEPC_OP_PAGE, 24'hFFFF00, 0);
        arm;
        xfer(`FEPC_CMD_PAGE_WRITE, 24'h0A0C00, 3, 1, 0, 4, 0, 0, 3'h0, 24'h0, 1);
        xfer(`FEPC_CMD_PAGE_WRITE, 24'h000010, 3, 258, 0, 0, C5, 1, `FEPC_OP_PAGE, 24'hFFFF00, 0);
        freeze_arm;
        xfer(`FEPC_CMD_SMALL_WIPE, 24'h002000, 3, 0, 0, 0, 0, 0, 3'h0, 24'h0, 0);
        status_read;
        arm;
        xfer(`FEPC_CMD_QUAD_PAGE_WRITE, 24'h000520, 3, 1, 0, 0, C5, 1, `FEPC_OP_PAGE, 24'hFFFF00, 0);
        mode_trip;
        xfer(`FEPC_CMD_QUAD_PAGE_WRITE, 24'h0300F0, 3, 2, 1, 0, C5, 1, `FEPC_OP_PAGE, 24'hFFFF00, 0);
        arm;
        xfer(`FEPC_CMD_QUAD_PAGE_WRITE, 24'h000300, 3, 256, 1, 0, C5, 1, `FEPC_OP_PAGE, 24'hFFFF00, 0);
        tally_and_finish;
    end
endmodule
